// [tb/test_uctl_top.sv]
`timescale 1ns/1ps
module test_uctl_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, host_role = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, irq_vector_in = 32'h0000_0000, rdv;
    logic        tx_loaded = 1'b0, tx_is_iso = 1'b0, err;
    logic [4:0]  tx_event = 5'h00;
    logic [3:0]  rx_event = 4'h0;
    logic [31:0] seed = 32'h84d9_170f;
    logic [6:0]  fa;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq_ack_pulse, tok_valid, tok_is_in, tok_is_sof;
    wire  [6:0]  tok_addr;
    wire         tok_match, iso_send_now, iso_send_zlp, rx_pkt_short, tx_irq;
    wire  [3:0]  rx_pkt_valid, dma_close;
    wire  [10:0] rx_pkt_bytes;
    wire         pin_bus_reset, pin_suspend, pin_remote_wake, phy_hs_ok;
    wire         dline_oe, hs_negotiate, resume_drive, suspend_out, suspend_irq_read;
    int          n_mismatch = 0, n_checks = 0, cyc = 0, i;
    int          n_ack = 0, n_match = 0, n_now = 0, n_zlp = 0;
    int          n_close [4] = '{0, 0, 0, 0};

    always #12.5 pclk = ~pclk;
    uctl_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq_vector_in, .irq_ack_pulse, .host_role, .tok_valid,
        .tok_is_in, .tok_is_sof, .tok_addr, .tok_match, .iso_send_now, .iso_send_zlp,
        .tx_loaded, .tx_is_iso, .rx_pkt_valid, .rx_pkt_bytes, .rx_pkt_short, .dma_close,
        .tx_event, .rx_event, .tx_irq, .pin_bus_reset, .pin_suspend, .pin_remote_wake,
        .phy_hs_ok, .dline_oe, .hs_negotiate, .resume_drive, .suspend_out,
        .suspend_irq_read);
    uctl_host_model host (.pclk, .tok_valid, .tok_is_in, .tok_is_sof, .tok_addr,
        .rx_pkt_valid, .rx_pkt_bytes, .rx_pkt_short, .pin_bus_reset, .pin_suspend,
        .pin_remote_wake, .phy_hs_ok);

    // ----------------------------------------
    // Pulse tallies and watchdog
    // ----------------------------------------
    always @(posedge pclk) begin
        n_ack <= n_ack + (irq_ack_pulse === 1'b1);
        n_match <= n_match + (tok_match === 1'b1);
        n_now <= n_now + (iso_send_now === 1'b1);
        n_zlp <= n_zlp + (iso_send_zlp === 1'b1);
        for (int k = 0; k < 4; k++) begin
            n_close[k] <= n_close[k] + (dma_close[k] === 1'b1);
        end
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        {pwrite, paddr, pwdata} <= {w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdv, exp);
    endtask
    task test_done();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h034, 32'h0000_0020);
        rd(12'h040, 32'h0000_001F);
        for (i = 0; i < 8; i++) rd(12'h010 + 12'(4 * i), 32'h0000_0000);
        rd(12'h00C, 32'h0000_0000);
        chk(err, 32'h0000_0001);
        $display("test reset done");
        seed = lfsr(seed);
        irq_vector_in <= seed;
        wr(12'h004, ~seed);
        rd(12'h004, {16'h0000, seed[15:0]});
        rd(12'h008, {16'h0000, seed[31:16]});
        wr(12'h000, 32'h0000_005A);
        wr(12'h000, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        chk(n_ack, 32'h0000_0001);
        seed = lfsr(seed);
        fa = seed[6:0];
        wr(12'h030, {25'h0, fa});
        rd(12'h030, {25'h0, fa});
        host.tok(fa, 1'b0, 1'b0);
        host.tok(fa ^ 7'h40, 1'b0, 1'b0);
        repeat (2) @(posedge pclk);
        chk(n_match, 32'h0000_0001);
        $display("test vector ack address done");
        // Limit of two 64-byte packets; a short packet closes early
        for (i = 0; i < 4; i++) wr(12'h010 + 12'(8 * i), 32'h0000_0080);
        wr(12'h044, 32'h0000_000F);
        for (i = 0; i < 4; i++) begin
            host.pkt(i, 11'd64, 1'b0);
            host.pkt(i, 11'd64, 1'b0);
            host.pkt(i, 11'd10, 1'b1);
            repeat (4) @(posedge pclk);
            chk(n_close[i], 32'h0000_0002);
        end
        $display("test aggregation done");
        seed = lfsr(seed);
        tx_event <= seed[4:0] | 5'h01;
        rx_event <= seed[8:5] | 4'h1;
        @(posedge pclk);
        {tx_event, rx_event} <= 9'h000;
        repeat (2) @(posedge pclk);
        chk(tx_irq, 32'h0000_0001);
        rd(12'h038, {27'h0, seed[4:0] | 5'h01});
        rd(12'h038, 32'h0000_0000);
        rd(12'h03C, {27'h0, seed[8:5] | 4'h1, 1'b0});
        rd(12'h03C, 32'h0000_0000);
        $display("test flags done");
        wr(12'h034, 32'h0000_0061);
        // Output launches at the edge that ends the write; look one edge later
        @(posedge pclk);
        chk(dline_oe, 32'h0000_0001);
        host.pins(1'b0, 1'b1, 1'b0, 1'b0);
        repeat (8) @(posedge pclk);
        rd(12'h034, 32'h0000_0063);
        chk(suspend_out, 32'h0000_0001);
        wr(12'h034, 32'h0000_0065);
        @(posedge pclk);
        chk(resume_drive, 32'h0000_0001);
        rd(12'h034, 32'h0000_0065);
        wr(12'h034, 32'h0000_0021);
        host.pins(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (8) @(posedge pclk);
        chk(resume_drive, 32'h0000_0000);
        chk(hs_negotiate, 32'h0000_0001);
        rd(12'h034, 32'h0000_0029);
        host.pins(1'b1, 1'b0, 1'b0, 1'b1);
        repeat (3) @(posedge pclk);
        rd(12'h034, 32'h0000_0039);
        host.pins(1'b0, 1'b0, 1'b0, 1'b0);
        $display("test power done");
        wr(12'h034, 32'h0000_00A0);
        {tx_loaded, tx_is_iso} <= 2'b11;
        host.tok(fa, 1'b1, 1'b0);
        host.tok(7'h00, 1'b0, 1'b1);
        host.tok(fa, 1'b1, 1'b0);
        repeat (2) @(posedge pclk);
        chk(n_zlp, 32'h0000_0001);
        chk(n_now, 32'h0000_0001);
        $display("test iso done");
        test_done();
    end
endmodule

// [tb/uctl_checker.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module uctl_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        irq_ack_pulse,
    input wire        tok_valid,
    input wire        tok_is_in,
    input wire        tok_match,
    input wire        iso_send_now,
    input wire        iso_send_zlp,
    input wire [3:0]  rx_pkt_valid,
    input wire [3:0]  dma_close
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ack;
        (psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[7:0] == 8'h00)
            |-> ##[0:2] irq_ack_pulse;
    endproperty
    a_ack: assert property (p_ack) else $error("ack pulse missing");
    property p_match;
        tok_match |-> $past(tok_valid);
    endproperty
    a_match: assert property (p_match) else $error("match without token");
    property p_close;
        dma_close != 4'h0 |-> (dma_close & ~$past(rx_pkt_valid, 2)) == 4'h0;
    endproperty
    a_close: assert property (p_close) else $error("close without packet");
    property p_iso;
        (iso_send_now || iso_send_zlp) |-> $past(tok_valid && tok_is_in);
    endproperty
    a_iso: assert property (p_iso) else $error("iso send without IN");
    property p_iso_one;
        !(iso_send_now && iso_send_zlp);
    endproperty
    a_iso_one: assert property (p_iso_one) else $error("both iso answers");
    // Unmapped hole must be refused so software sees no phantom register
    property p_hole;
        (psel && !penable && paddr == 12'h00C) ##1 penable |=> pready && pslverr;
    endproperty
    a_hole: assert property (p_hole) else $error("hole not refused");
    property p_hole_rd;
        (pready && pslverr && !pwrite) |-> prdata == 32'h0000_0000;
    endproperty
    a_hole_rd: assert property (p_hole_rd) else $error("refused read not zero");
    property p_rdy_cause;
        pready |-> $past(psel && penable);
    endproperty
    a_rdy_cause: assert property (p_rdy_cause) else $error("ready without access");
    property p_rdy_one;
        pready |=> !pready;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
endmodule
bind uctl_top uctl_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq_ack_pulse, .tok_valid, .tok_is_in,
    .tok_match, .iso_send_now, .iso_send_zlp, .rx_pkt_valid, .dma_close);

// [tb/uctl_host_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Bus host model: tokens, packets, line states
// ----------------------------------------
module uctl_host_model (
    input  wire        pclk,
    output logic       tok_valid,
    output logic       tok_is_in,
    output logic       tok_is_sof,
    output logic [6:0] tok_addr,
    output logic [3:0] rx_pkt_valid,
    output logic [10:0] rx_pkt_bytes,
    output logic       rx_pkt_short,
    output logic       pin_bus_reset,
    output logic       pin_suspend,
    output logic       pin_remote_wake,
    output logic       phy_hs_ok
);
    initial begin
        {tok_valid, tok_is_in, tok_is_sof, tok_addr} = 10'h000;
        {rx_pkt_valid, rx_pkt_bytes, rx_pkt_short} = 16'h0000;
        {pin_bus_reset, pin_suspend, pin_remote_wake, phy_hs_ok} = 4'h0;
    end
    // Idle qualifiers flip so a design that ignores valid is caught
    task tok(input logic [6:0] a, input logic in, input logic sof);
        @(posedge pclk);
        {tok_valid, tok_is_in, tok_is_sof, tok_addr} <= {1'b1, in, sof, a};
        @(posedge pclk);
        {tok_valid, tok_is_in, tok_is_sof, tok_addr} <= {1'b0, ~in, ~sof, ~a};
    endtask
    task pkt(input int ep, input logic [10:0] n, input logic sh);
        @(posedge pclk);
        rx_pkt_valid <= 4'h1 << ep;
        {rx_pkt_bytes, rx_pkt_short} <= {n, sh};
        @(posedge pclk);
        rx_pkt_valid <= 4'h0;
        {rx_pkt_bytes, rx_pkt_short} <= {~n, ~sh};
    endtask
    task pins(input logic rst, input logic sus, input logic wake, input logic hs);
        @(posedge pclk);
        {pin_bus_reset, pin_suspend, pin_remote_wake, phy_hs_ok} <= {rst, sus, wake, hs};
    endtask
endmodule

// [verilog/uctl_agg_ep.v]
`timescale 1ns/1ps
`include "uctl_consts.vh"
// ----------------------------------------
// Per-endpoint receive aggregation counter
// ----------------------------------------
module uctl_agg_ep (
    input  wire                   pclk,
    input  wire                   presetn,
    input  wire                   agg_mode,
    input  wire [`UCTL_CNT_W-1:0] agg_limit,
    input  wire                   pkt_valid,
    input  wire [10:0]            pkt_bytes,
    input  wire                   pkt_short,
    output reg                    dma_close_q
);
    reg  [`UCTL_CNT_W-1:0] acc_q;
    wire [`UCTL_CNT_W-1:0] acc_sum;

    assign acc_sum = acc_q + {6'b0, pkt_bytes};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q       <= {`UCTL_CNT_W{1'b0}};
            dma_close_q <= 1'b0;
        end else begin
            dma_close_q <= 1'b0;
            if (!agg_mode) begin
                acc_q       <= {`UCTL_CNT_W{1'b0}};
                dma_close_q <= pkt_valid;
            end else if (pkt_valid) begin
                // Short packet or full count ends the DMA packet
                if (pkt_short || acc_sum >= agg_limit) begin
                    acc_q       <= {`UCTL_CNT_W{1'b0}};
                    dma_close_q <= 1'b1;
                end else begin
                    acc_q <= acc_sum;
                end
            end
        end
    end
endmodule

// [verilog/uctl_consts.vh]
`ifndef UCTL_CONSTS_VH
`define UCTL_CONSTS_VH
// ----------------------------------------
// Register byte addresses (word aligned)
// ----------------------------------------
`define UCTL_A_EOI      12'h000
`define UCTL_A_VEC_LO   12'h004
`define UCTL_A_VEC_HI   12'h008
`define UCTL_A_AGG_BASE 12'h010
`define UCTL_A_BUS_FUNCTION_ADDRESS    12'h030
`define UCTL_A_POWER    12'h034
`define UCTL_A_TXFLAG   12'h038
`define UCTL_A_RXFLAG   12'h03C
`define UCTL_A_TXEN     12'h040
`define UCTL_A_AGGMODE  12'h044
`define UCTL_A_LAST     12'h044
`define UCTL_A_HOLE     12'h00C
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define UCTL_PW_ISO      7
`define UCTL_PW_SOFT     6
`define UCTL_PW_HIGH_SPEED_ALLOW     5
`define UCTL_PW_HSACT    4
`define UCTL_PW_RST      3
`define UCTL_PW_RESUME   2
`define UCTL_PW_SUSP     1
`define UCTL_PW_SUSPOE   0
`define UCTL_POWER_RST   8'h20
`define UCTL_TXEN_RST    5'h1F
`define UCTL_EOI_ACK     8'h00
`define UCTL_ADDR_W      7
`define UCTL_CNT_W       17
`define UCTL_NUM_EP      4
`endif

// [verilog/uctl_sync3.v]
`timescale 1ns/1ps
// ----------------------------------------
// Three-stage pin synchroniser with agreement filter
// ----------------------------------------
module uctl_sync3 #(
    parameter W = 1
) (
    input  wire         pclk,
    input  wire         presetn,
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] level_q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer     i;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q    <= {W{1'b0}};
            s2_q    <= {W{1'b0}};
            s3_q    <= {W{1'b0}};
            level_q <= {W{1'b0}};
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Change counts only once the last two stages agree
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// [verilog/uctl_top.v]
`timescale 1ns/1ps
`include "uctl_consts.vh"
// Operation
// - Writing zero to ack field acknowledges interrupt
// - Input vector readable as two halves
// - Aggregate packets until count or short
// - Four 17-bit counts, reset zero
// - Match tokens against programmed device address
// - Iso packet waits for next frame start
// - IN before frame start gets empty packet
// - Soft attach drives or releases data lines
// - High speed allowed at reset, default on
// - Report successful high-speed negotiation
// - Report bus reset presence
// - Drive resume while bit set and suspended
// - Host role sets resume on remote wakeup
// - Suspend status set on entry, cleared
// - Suspend output only when enabled
// - Tx flags: endpoint 0 and 1-4
// - Rx flags: endpoints 1-4, bit 0 zero
// - Tx enable register, bits reset one
module uctl_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [31:0] irq_vector_in,
    output reg         irq_ack_pulse,
    input  wire        host_role,
    input  wire        tok_valid,
    input  wire        tok_is_in,
    input  wire        tok_is_sof,
    input  wire [6:0]  tok_addr,
    output reg         tok_match,
    output reg         iso_send_now,
    output reg         iso_send_zlp,
    input  wire        tx_loaded,
    input  wire        tx_is_iso,
    input  wire [3:0]  rx_pkt_valid,
    input  wire [10:0] rx_pkt_bytes,
    input  wire        rx_pkt_short,
    output reg  [3:0]  dma_close,
    input  wire [4:0]  tx_event,
    input  wire [3:0]  rx_event,
    output reg         tx_irq,
    input  wire        pin_bus_reset,
    input  wire        pin_suspend,
    input  wire        pin_remote_wake,
    input  wire        phy_hs_ok,
    output reg         dline_oe,
    output reg         hs_negotiate,
    output reg         resume_drive,
    output reg         suspend_out,
    output reg         suspend_irq_read
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    reg  [7:0]             eoi_q;
    reg  [6:0]             bus_device_address_q;
    reg  [7:0]             power_q;
    reg  [4:0]             tx_flag_q;
    reg  [3:0]             rx_flag_q;
    reg  [4:0]             tx_en_q;
    reg  [3:0]             agg_mode_q;
    reg  [15:0]            agg_low_q [0:3];
    reg  [3:0]             agg_top_q;
    reg                    iso_armed_q;
    reg                    susp_prev_q;
    reg                    rst_prev_q;
    wire [2:0]             pin_lvl;
    wire                   bus_rst;
    wire                   bus_susp;
    wire                   bus_wake;
    wire [3:0]             close_w;
    wire                   wr_en;
    wire                   rd_en;
    wire [3:0]             agg_idx;
    wire                   agg_hit;
    reg  [31:0]            rd_d;
    integer                k;

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign agg_idx = paddr[6:3] - 4'h2;
    assign agg_hit = (paddr >= `UCTL_A_AGG_BASE) && (paddr < `UCTL_A_BUS_FUNCTION_ADDRESS);

    function addr_ok;
        input [11:0] a;
        begin
            addr_ok = (a[1:0] == 2'b00) && (a <= `UCTL_A_LAST) && (a != `UCTL_A_HOLE);
        end
    endfunction

    uctl_sync3 #(.W(3)) u_pins (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({pin_remote_wake, pin_suspend, pin_bus_reset}),
        .level_q (pin_lvl)
    );
    assign bus_rst  = pin_lvl[0];
    assign bus_susp = pin_lvl[1];
    assign bus_wake = pin_lvl[2];

    genvar g;
    generate
        for (g = 0; g < `UCTL_NUM_EP; g = g + 1) begin : g_agg
            uctl_agg_ep u_agg (
                .pclk        (pclk),
                .presetn     (presetn),
                .agg_mode    (agg_mode_q[g]),
                .agg_limit   ({agg_top_q[g], agg_low_q[g]}),
                .pkt_valid   (rx_pkt_valid[g]),
                .pkt_bytes   (rx_pkt_bytes),
                .pkt_short   (rx_pkt_short),
                .dma_close_q (close_w[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always @* begin
        rd_d = 32'h0000_0000;
        if (agg_hit) begin
            if (paddr[2]) begin
                rd_d = {31'h0000_0000, agg_top_q[agg_idx[1:0]]};
            end else begin
                rd_d = {16'h0000, agg_low_q[agg_idx[1:0]]};
            end
        end else begin
            case (paddr)
                `UCTL_A_EOI:     rd_d = {24'h00_0000, eoi_q};
                `UCTL_A_VEC_LO:  rd_d = {16'h0000, irq_vector_in[15:0]};
                `UCTL_A_VEC_HI:  rd_d = {16'h0000, irq_vector_in[31:16]};
                `UCTL_A_BUS_FUNCTION_ADDRESS:   rd_d = {25'h000_0000, bus_device_address_q};
                `UCTL_A_POWER:   rd_d = {24'h00_0000, power_q};
                `UCTL_A_TXFLAG:  rd_d = {27'h000_0000, tx_flag_q};
                `UCTL_A_RXFLAG:  rd_d = {27'h000_0000, rx_flag_q, 1'b0};
                `UCTL_A_TXEN:    rd_d = {27'h000_0000, tx_en_q};
                `UCTL_A_AGGMODE: rd_d = {28'h000_0000, agg_mode_q};
                default:         rd_d = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // APB slave and registers
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata               <= 32'h0000_0000;
            pready               <= 1'b0;
            pslverr              <= 1'b0;
            eoi_q                <= 8'h00;
            irq_ack_pulse        <= 1'b0;
            bus_device_address_q <= 7'h00;
            power_q              <= `UCTL_POWER_RST;
            tx_flag_q            <= 5'h00;
            rx_flag_q            <= 4'h0;
            tx_en_q              <= `UCTL_TXEN_RST;
            agg_mode_q           <= 4'h0;
            agg_top_q            <= 4'h0;
            suspend_irq_read     <= 1'b0;
            susp_prev_q          <= 1'b0;
            rst_prev_q           <= 1'b0;
            for (k = 0; k < 4; k = k + 1) begin
                agg_low_q[k] <= 16'h0000;
            end
        end else begin
            // Single wait state keeps read data registered
            pready           <= psel & penable & ~pready;
            pslverr          <= psel & penable & ~pready & ~addr_ok(paddr);
            irq_ack_pulse    <= 1'b0;
            suspend_irq_read <= 1'b0;
            susp_prev_q      <= bus_susp;
            rst_prev_q       <= bus_rst;
            if (rd_en && !pready) begin
                prdata <= rd_d;
            end
            // Flags: events set, read clears; a same-cycle event wins
            tx_flag_q <= tx_flag_q;
            rx_flag_q <= rx_flag_q;
            if (rd_en && pready && paddr == `UCTL_A_TXFLAG) begin
                tx_flag_q        <= 5'h00;
                suspend_irq_read <= 1'b1;
            end
            if (rd_en && pready && paddr == `UCTL_A_RXFLAG) begin
                rx_flag_q <= 4'h0;
            end
            tx_flag_q <= ((rd_en && pready && paddr == `UCTL_A_TXFLAG) ? 5'h00 : tx_flag_q)
                         | tx_event;
            rx_flag_q <= ((rd_en && pready && paddr == `UCTL_A_RXFLAG) ? 4'h0 : rx_flag_q)
                         | rx_event;
            // Read-only status bits track the bus
            power_q[`UCTL_PW_RST] <= bus_rst;
            if (bus_rst && !rst_prev_q) begin
                power_q[`UCTL_PW_HSACT] <= 1'b0;
            end else if (bus_rst && power_q[`UCTL_PW_HIGH_SPEED_ALLOW] && phy_hs_ok) begin
                power_q[`UCTL_PW_HSACT] <= 1'b1;
            end
            if (bus_susp && !susp_prev_q) begin
                power_q[`UCTL_PW_SUSP] <= 1'b1;
            end else if (suspend_irq_read || power_q[`UCTL_PW_RESUME]) begin
                power_q[`UCTL_PW_SUSP] <= 1'b0;
            end
            if (host_role && power_q[`UCTL_PW_SUSP] && bus_wake) begin
                power_q[`UCTL_PW_RESUME] <= 1'b1;
            end
            if (wr_en && pready) begin
                if (agg_hit) begin
                    if (paddr[2]) begin
                        agg_top_q[agg_idx[1:0]] <= pwdata[0];
                    end else begin
                        agg_low_q[agg_idx[1:0]] <= pwdata[15:0];
                    end
                end
                case (paddr)
                    `UCTL_A_EOI: begin
                        eoi_q <= pwdata[7:0];
                        irq_ack_pulse <= (pwdata[7:0] == `UCTL_EOI_ACK);
                    end
                    `UCTL_A_BUS_FUNCTION_ADDRESS:   bus_device_address_q <= pwdata[6:0];
                    `UCTL_A_POWER: begin
                        power_q[`UCTL_PW_ISO]    <= pwdata[`UCTL_PW_ISO];
                        power_q[`UCTL_PW_SOFT]   <= pwdata[`UCTL_PW_SOFT];
                        power_q[`UCTL_PW_HIGH_SPEED_ALLOW]   <= pwdata[`UCTL_PW_HIGH_SPEED_ALLOW];
                        power_q[`UCTL_PW_RESUME] <= pwdata[`UCTL_PW_RESUME];
                        power_q[`UCTL_PW_SUSPOE] <= pwdata[`UCTL_PW_SUSPOE];
                        if (pwdata[`UCTL_PW_RESUME]) begin
                            power_q[`UCTL_PW_SUSP] <= 1'b0;
                        end
                    end
                    `UCTL_A_TXEN:    tx_en_q    <= pwdata[4:0];
                    `UCTL_A_AGGMODE: agg_mode_q <= pwdata[3:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Link-side outputs
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tok_match    <= 1'b0;
            iso_send_now <= 1'b0;
            iso_send_zlp <= 1'b0;
            iso_armed_q  <= 1'b0;
            dma_close    <= 4'h0;
            tx_irq       <= 1'b0;
            dline_oe     <= 1'b0;
            hs_negotiate <= 1'b0;
            resume_drive <= 1'b0;
            suspend_out  <= 1'b0;
        end else begin
            // Token address compared with programmed one in either host_role setting
            tok_match <= tok_valid && (tok_addr == bus_device_address_q);
            iso_send_now <= 1'b0;
            iso_send_zlp <= 1'b0;
            if (!tx_loaded) begin
                iso_armed_q <= 1'b0;
            end else if (tx_is_iso && power_q[`UCTL_PW_ISO]) begin
                if (tok_valid && tok_is_sof) begin
                    iso_armed_q <= 1'b1;
                end else if (tok_valid && tok_is_in) begin
                    iso_send_now <= iso_armed_q;
                    iso_send_zlp <= ~iso_armed_q;
                end
            end else if (tok_valid && tok_is_in) begin
                iso_send_now <= 1'b1;
            end
            dma_close    <= close_w;
            tx_irq       <= |(tx_flag_q & tx_en_q);
            dline_oe     <= power_q[`UCTL_PW_SOFT];
            hs_negotiate <= bus_rst & power_q[`UCTL_PW_HIGH_SPEED_ALLOW];
            resume_drive <= power_q[`UCTL_PW_RESUME] & bus_susp;
            suspend_out  <= power_q[`UCTL_PW_SUSPOE] & power_q[`UCTL_PW_SUSP];
        end
    end
endmodule
